// ---- hw/aibu_top.sv ----
// Auxiliary interrupt aggregation, standard enable gating and address breakpoints.
`timescale 1ns/1ns
`include "aibu_consts.svh"

module aibu_top #(
  parameter logic [7:0] ONE_HZ_ADDR = `AIBU_DEF_ONE_HZ_ADDR,
  parameter logic [7:0] KHZ_ADDR = `AIBU_DEF_KHZ_ADDR,
  parameter logic [7:0] SUM_LSB_ADDR = `AIBU_DEF_SUM_LSB_ADDR,
  parameter logic [7:0] ADC_LSB_ADDR = `AIBU_DEF_ADC_LSB_ADDR
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // Special function register bus from the core
  input wire aibu_pkg::aibu_sfr_req_t sfr_req,
  output logic [7:0] sfr_rdata_q,
  output logic sfr_rdata_valid_q,
  // Auxiliary event pulses from on-chip logic
  input wire logic one_hz_tick,
  input wire logic khz_tick,
  input wire logic accumulator_done,
  input wire logic conversion_done,
  input wire logic serial_periph_tx_done,
  input wire logic serial_periph_rx_done,
  // Supply detectors, asynchronous levels, high while below threshold
  input wire logic analog_lowv,
  input wire logic digital_lowv,
  // Standard sources
  input wire logic timer_a_overflow,
  input wire logic timer_b_overflow,
  input wire logic timer_c_overflow,
  input wire logic uart_a_rx_done,
  input wire logic uart_a_tx_done,
  input wire logic uart_b_rx_done,
  input wire logic uart_b_tx_done,
  input wire logic pin_irq_a,
  input wire logic pin_irq_b,
  // Breakpoint slot selection and memory access observation
  input wire logic [`AIBU_SLOT_W-1:0] memory_control_selector,
  input wire aibu_pkg::aibu_mem_access_t mem_access,
  // Requests to the core
  output logic aux_irq_req_q,
  output logic [15:0] aux_irq_vector,
  output logic [3:0] aux_pending_q,
  output logic [6:0] std_irq_req_q,
  output logic conversion_update_block,
  output logic break_hit_any
);

  // ==========================================================================
  // Helpers

  function automatic logic [3:0] aibu_pend_code(input logic [7:0] f);
    logic [3:0] code;
    code = `AIBU_PEND_NONE;
    for (int i = 7; i >= 0; i--) begin
      if (f[i]) begin
        code = 4'(i + 1);
      end
    end
    return code;
  endfunction

  function automatic logic aibu_any_hit(input aibu_pkg::aibu_slot_t [`AIBU_SLOTS-1:0] s);
    logic any;
    any = 1'b0;
    for (int k = 0; k < `AIBU_SLOTS; k++) begin
      any = any | s[k].hit;
    end
    return any;
  endfunction

  // ==========================================================================
  // State

  aibu_pkg::aibu_state_t s_q;
  aibu_pkg::aibu_state_t s_d;
  logic [7:0] raw;
  logic [7:0] flags;
  logic hit_any;
  logic wr_mask;
  logic wr_stdie;
  logic wr_ext_irq_control;
  logic wr_break_control;
  logic wr_bpl;
  logic wr_bph;
  logic wr_spi;
  logic rd_spi;
  logic rd_one_hz;
  logic rd_khz;
  logic rd_sum;
  logic rd_adc;
  logic [5:0] ev_set;
  logic [5:0] ev_clr;
  logic [6:0] std_src;
  logic [7:0] break_control_rd;
  aibu_pkg::aibu_slot_t sel_slot;

  always_comb begin
    hit_any = aibu_any_hit(s_q.slot);
    raw = {s_q.ev, s_q.alv_sync, s_q.dlv_sync | hit_any};
    flags = raw & s_q.mask;
    sel_slot = s_q.slot[memory_control_selector];
    break_control_rd = `AIBU_RESET_BYTE;
    break_control_rd[`AIBU_BP_HIT_BIT] = hit_any;
    break_control_rd[`AIBU_BP_SPACE_BIT] = sel_slot.space;
    break_control_rd[`AIBU_BP_ARM_BIT] = sel_slot.arm;
  end

  // ==========================================================================
  // Bus decode

  always_comb begin
    wr_mask = sfr_req.wr && (sfr_req.addr == `AIBU_ADDR_MASK);
    wr_stdie = sfr_req.wr && (sfr_req.addr == `AIBU_ADDR_STDIE);
    wr_ext_irq_control = sfr_req.wr && (sfr_req.addr == `AIBU_ADDR_EXT_IRQ_CONTROL);
    wr_break_control = sfr_req.wr && (sfr_req.addr == `AIBU_ADDR_BREAK_CONTROL);
    wr_bpl = sfr_req.wr && (sfr_req.addr == `AIBU_ADDR_BPL);
    wr_bph = sfr_req.wr && (sfr_req.addr == `AIBU_ADDR_BPH);
    wr_spi = sfr_req.wr && (sfr_req.addr == `AIBU_ADDR_SERIAL_PERIPH_DATA_REG);
    rd_spi = sfr_req.rd && (sfr_req.addr == `AIBU_ADDR_SERIAL_PERIPH_DATA_REG);
    rd_one_hz = sfr_req.rd && (sfr_req.addr == ONE_HZ_ADDR);
    rd_khz = sfr_req.rd && (sfr_req.addr == KHZ_ADDR);
    rd_sum = sfr_req.rd && (sfr_req.addr == SUM_LSB_ADDR);
    rd_adc = sfr_req.rd && (sfr_req.addr == ADC_LSB_ADDR);
  end

  // ==========================================================================
  // Auxiliary events
  // A new event in the same cycle as its clearing access stays set, so no
  // event is lost to a racing read or write.

  always_comb begin
    ev_set = {one_hz_tick, accumulator_done, conversion_done, khz_tick,
              serial_periph_tx_done, serial_periph_rx_done};
    ev_clr = {rd_one_hz, rd_sum, rd_adc, rd_khz, wr_spi, rd_spi};
  end

  always_comb begin
    std_src = {uart_b_rx_done | uart_b_tx_done, timer_c_overflow,
               uart_a_rx_done | uart_a_tx_done, timer_b_overflow,
               pin_irq_b, timer_a_overflow, pin_irq_a};
  end

  // ==========================================================================
  // Next state

  always_comb begin
    s_d = s_q;
    s_d.alv_meta = analog_lowv;
    s_d.alv_sync = s_q.alv_meta;
    s_d.dlv_meta = digital_lowv;
    s_d.dlv_sync = s_q.dlv_meta;
    // Flag clearing side effects
    s_d.ev = (s_q.ev & ~ev_clr) | ev_set;
    if (wr_mask) begin
      s_d.mask = sfr_req.wdata;
    end
    if (wr_stdie) begin
      s_d.std_ie = sfr_req.wdata;
    end
    if (wr_ext_irq_control) begin
      s_d.aux_en = sfr_req.wdata[`AIBU_EXT_IRQ_CONTROL_AUX_BIT];
    end
    if (wr_bpl) begin
      s_d.break_addr_low = sfr_req.wdata;
    end
    if (wr_bph) begin
      s_d.break_addr_high = sfr_req.wdata;
    end
    for (int k = 0; k < `AIBU_SLOTS; k++) begin
      if (wr_break_control && (int'(memory_control_selector) == k)) begin
        s_d.slot[k].arm = sfr_req.wdata[`AIBU_BP_ARM_BIT];
        s_d.slot[k].space = sfr_req.wdata[`AIBU_BP_SPACE_BIT];
        s_d.slot[k].addr = {s_q.break_addr_high, s_q.break_addr_low};
        if (sfr_req.wdata[`AIBU_BP_HIT_BIT]) begin
          s_d.slot[k].hit = 1'b0;
        end
      end
      if (mem_access.valid && s_q.slot[k].arm && (mem_access.space == s_q.slot[k].space)
          && (mem_access.addr == s_q.slot[k].addr)) begin
        s_d.slot[k].hit = 1'b1;
      end
    end
    // Register read mux
    s_d.rvalid = 1'b0;
    s_d.rdata = `AIBU_RESET_BYTE;
    if (sfr_req.rd) begin
      case (sfr_req.addr)
        `AIBU_ADDR_PEND: begin
          s_d.rvalid = 1'b1;
          s_d.rdata = {4'h0, aibu_pend_code(flags)};
        end
        `AIBU_ADDR_MASK: begin
          s_d.rvalid = 1'b1;
          s_d.rdata = raw;
        end
        `AIBU_ADDR_FLAGS: begin
          s_d.rvalid = 1'b1;
          s_d.rdata = flags;
        end
        `AIBU_ADDR_STDIE: begin
          s_d.rvalid = 1'b1;
          s_d.rdata = s_q.std_ie;
        end
        `AIBU_ADDR_BREAK_CONTROL: begin
          s_d.rvalid = 1'b1;
          s_d.rdata = break_control_rd;
        end
        `AIBU_ADDR_BPL: begin
          s_d.rvalid = 1'b1;
          s_d.rdata = s_q.break_addr_low;
        end
        `AIBU_ADDR_BPH: begin
          s_d.rvalid = 1'b1;
          s_d.rdata = s_q.break_addr_high;
        end
        `AIBU_ADDR_EXT_IRQ_CONTROL: begin
          s_d.rvalid = 1'b1;
          s_d.rdata[`AIBU_EXT_IRQ_CONTROL_AUX_BIT] = s_q.aux_en;
        end
        default: begin
          s_d.rvalid = 1'b0;
        end
      endcase
    end
    s_d.aux_req = s_q.aux_en && (flags != 8'h00);
    s_d.pend = aibu_pend_code(flags);
    s_d.std_req = s_q.std_ie[`AIBU_EA_BIT] ? (s_q.std_ie[6:0] & std_src) : 7'h00;
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // ==========================================================================
  // Outputs
  // The requests are registered, so they trail the flags and standard sources by one cycle; the
  // core samples them once per instruction and does not notice.

  assign sfr_rdata_q = s_q.rdata;
  assign sfr_rdata_valid_q = s_q.rvalid;
  assign aux_irq_req_q = s_q.aux_req;
  assign aux_pending_q = s_q.pend;
  assign std_irq_req_q = s_q.std_req;
  assign aux_irq_vector = `AIBU_AUX_VECTOR;
  assign conversion_update_block = raw[`AIBU_SRC_ADC];
  assign break_hit_any = hit_any;

  // ==========================================================================
  // Checks

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  property p_pend_code;
    1 |=> aux_pending_q == aibu_pend_code($past(flags));
  endproperty
  a_pend_code: assert property (p_pend_code) else $error("Pending index wrong.");

  property p_aux_gate;
    !s_q.aux_en |=> !aux_irq_req_q;
  endproperty
  a_aux_gate: assert property (p_aux_gate) else $error("Aux request without enable.");

  property p_raw_read;
    sfr_req.rd && (sfr_req.addr == `AIBU_ADDR_MASK) |=> sfr_rdata_valid_q && (sfr_rdata_q == $past(raw));
  endproperty
  a_raw_read: assert property (p_raw_read) else $error("Mask read not raw.");

  property p_status;
    sfr_req.rd && (sfr_req.addr == `AIBU_ADDR_FLAGS) |=> sfr_rdata_q == ($past(raw) & $past(s_q.mask));
  endproperty
  a_status: assert property (p_status) else $error("Status not masked.");

  property p_tx_clear;
    wr_spi && !serial_periph_tx_done |=> !raw[`AIBU_SRC_SERIAL_PERIPH_TX_FLAG];
  endproperty
  a_tx_clear: assert property (p_tx_clear) else $error("Transmit flag not cleared.");

  property p_rx_clear;
    rd_spi && !serial_periph_rx_done |=> !raw[`AIBU_SRC_SERIAL_PERIPH_RX_FLAG];
  endproperty
  a_rx_clear: assert property (p_rx_clear) else $error("Receive flag not cleared.");

  property p_sec_set;
    one_hz_tick |=> raw[`AIBU_SRC_SEC];
  endproperty
  a_sec_set: assert property (p_sec_set) else $error("Second flag lost.");

  property p_alv_follow;
    analog_lowv ##1 analog_lowv |=> raw[`AIBU_SRC_ALV];
  endproperty
  a_alv_follow: assert property (p_alv_follow) else $error("Analog flag not following.");

  property p_ea_gate;
    !s_q.std_ie[`AIBU_EA_BIT] |=> std_irq_req_q == 7'h00;
  endproperty
  a_ea_gate: assert property (p_ea_gate) else $error("Standard request without gate.");

  property p_adc_block;
    conversion_done |=> conversion_update_block;
  endproperty
  a_adc_block: assert property (p_adc_block) else $error("Conversion block missing.");

  property p_hit_clear;
    wr_break_control && sfr_req.wdata[`AIBU_BP_HIT_BIT] && !mem_access.valid |=> !sel_slot.hit;
  endproperty
  a_hit_clear: assert property (p_hit_clear) else $error("Hit not cleared.");

  property p_hit_raise;
    mem_access.valid && sel_slot.arm && (mem_access.space == sel_slot.space)
      && (mem_access.addr == sel_slot.addr) |=> raw[`AIBU_SRC_DLVB] ##1 aux_pending_q == 4'h1 || !s_q.mask[0];
  endproperty
  a_hit_raise: assert property (p_hit_raise) else $error("Breakpoint hit not raised.");

  property p_mask_write;
    wr_mask |=> s_q.mask == $past(sfr_req.wdata);
  endproperty
  a_mask_write: assert property (p_mask_write) else $error("Mask write lost.");

  property p_khz_clear;
    rd_khz && !khz_tick |=> !raw[`AIBU_SRC_KHZ];
  endproperty
  a_khz_clear: assert property (p_khz_clear) else $error("Millisecond flag not cleared.");

  property p_sum_clear;
    rd_sum && !accumulator_done |=> !raw[`AIBU_SRC_SUM];
  endproperty
  a_sum_clear: assert property (p_sum_clear) else $error("Accumulator flag not cleared.");

  property p_pin_gate;
    s_q.std_ie[`AIBU_EA_BIT] && s_q.std_ie[0] && pin_irq_a |=> std_irq_req_q[0];
  endproperty
  a_pin_gate: assert property (p_pin_gate) else $error("Pin request not passed.");

  property p_uart_pass;
    s_q.std_ie[`AIBU_EA_BIT] && s_q.std_ie[4] && uart_a_tx_done |=> std_irq_req_q[4];
  endproperty
  a_uart_pass: assert property (p_uart_pass) else $error("Serial request not passed.");

  property p_slot_commit;
    wr_break_control && (memory_control_selector == 1'b0) |=> s_q.slot[0].addr == {$past(s_q.break_addr_high), $past(s_q.break_addr_low)};
  endproperty
  a_slot_commit: assert property (p_slot_commit) else $error("Slot address not committed.");

  c_aux_req: cover property (s_q.aux_en && one_hz_tick ##[1:3] aux_irq_req_q);
  c_lowv: cover property (raw[`AIBU_SRC_ALV] ##1 aux_pending_q == 4'h2);
  c_rx_clear: cover property (rd_spi ##1 !raw[`AIBU_SRC_SERIAL_PERIPH_RX_FLAG]);
  c_break: cover property (wr_break_control ##[1:20] break_hit_any);
  c_std_req: cover property (std_irq_req_q != 7'h00);

endmodule

// ---- hw/aibu_consts.svh ----
// Constants for the auxiliary interrupt and breakpoint unit.
`ifndef AIBU_CONSTS_SVH
`define AIBU_CONSTS_SVH

// ==========================================================================
// Register addresses
`define AIBU_ADDR_PEND 8'hA5
`define AIBU_ADDR_MASK 8'hA6
`define AIBU_ADDR_FLAGS 8'hA7
`define AIBU_ADDR_STDIE 8'hA8
`define AIBU_ADDR_BREAK_CONTROL 8'hA9
`define AIBU_ADDR_BPL 8'hAA
`define AIBU_ADDR_BPH 8'hAB
`define AIBU_ADDR_EXT_IRQ_CONTROL 8'hD8
`define AIBU_ADDR_SERIAL_PERIPH_DATA_REG 8'h9B
`define AIBU_DEF_ONE_HZ_ADDR 8'hFA
`define AIBU_DEF_KHZ_ADDR 8'hFB
`define AIBU_DEF_SUM_LSB_ADDR 8'hFC
`define AIBU_DEF_ADC_LSB_ADDR 8'hFD

// ==========================================================================
// Field positions and values
`define AIBU_EXT_IRQ_CONTROL_AUX_BIT 4
`define AIBU_EA_BIT 7
`define AIBU_BP_HIT_BIT 7
`define AIBU_BP_SPACE_BIT 1
`define AIBU_BP_ARM_BIT 0
`define AIBU_SRC_DLVB 0
`define AIBU_SRC_ALV 1
`define AIBU_SRC_SERIAL_PERIPH_RX_FLAG 2
`define AIBU_SRC_SERIAL_PERIPH_TX_FLAG 3
`define AIBU_SRC_KHZ 4
`define AIBU_SRC_ADC 5
`define AIBU_SRC_SUM 6
`define AIBU_SRC_SEC 7
`define AIBU_RESET_BYTE 8'h00
`define AIBU_PEND_NONE 4'h0
`define AIBU_AUX_VECTOR 16'h0033
`define AIBU_SLOTS 2
`define AIBU_SLOT_W 1

`endif

// ---- hw/aibu_pkg.sv ----
// Types of the auxiliary interrupt and breakpoint unit.
`include "aibu_consts.svh"

package aibu_pkg;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } aibu_sfr_req_t;

  typedef struct packed {
    logic valid;
    logic space;
    logic [15:0] addr;
  } aibu_mem_access_t;

  typedef struct packed {
    logic arm;
    logic space;
    logic [15:0] addr;
    logic hit;
  } aibu_slot_t;

  typedef struct packed {
    logic alv_meta;
    logic alv_sync;
    logic dlv_meta;
    logic dlv_sync;
    logic [5:0] ev;
    logic [7:0] mask;
    logic [7:0] std_ie;
    logic aux_en;
    logic [7:0] break_addr_low;
    logic [7:0] break_addr_high;
    aibu_slot_t [`AIBU_SLOTS-1:0] slot;
    logic [7:0] rdata;
    logic rvalid;
    logic aux_req;
    logic [3:0] pend;
    logic [6:0] std_req;
  } aibu_state_t;

endpackage

// ---- tb/aibu_core_model.sv ----
// Processor core model issuing special function register accesses.
`timescale 1ns/1ns

module aibu_core_model (
  // Clock
  input wire logic ref_clk,
  // Register bus
  output aibu_pkg::aibu_sfr_req_t sfr_req,
  input wire logic [7:0] sfr_rdata_q,
  input wire logic sfr_rdata_valid_q
);
  initial sfr_req = '0;

  // ==========================================================================
  // Bus cycles
  // Between strobes the address and data are inverted, so a stale value can never look valid.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    sfr_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge ref_clk);
    sfr_req <= '{addr: ~a, wdata: ~d, wr: 1'b0, rd: 1'b0};
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
    @(posedge ref_clk);
    sfr_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge ref_clk);
    sfr_req <= '{addr: ~a, wdata: 8'hFF, wr: 1'b0, rd: 1'b0};
    @(negedge ref_clk);
    d = sfr_rdata_q;
    v = sfr_rdata_valid_q;
  endtask
endmodule

// ---- tb/tb_aux_interrupt_and_breakpoint_unit.sv ----
// Self-checking bench of the auxiliary interrupt and breakpoint unit.
`timescale 1ns/1ns
`include "aibu_consts.svh"
`define CHK(got, exp) begin n_tests++; if ((got) !== (exp)) begin \
  $display("MISMATCH t=%0t got=%0h exp=%0h", $time, got, exp); \
  n_errors++; end end

module tb_aux_interrupt_and_breakpoint_unit;
  logic ref_clk = 1'b0;
  logic reset_n = 1'b0;
  logic [7:2] ev = '0;
  logic alv = 1'b0;
  logic dlv = 1'b0;
  logic [8:0] src = '0;
  logic sel = 1'b0;
  aibu_pkg::aibu_mem_access_t acc = '0;
  aibu_pkg::aibu_sfr_req_t req;
  logic [7:0] rdata;
  logic rvalid, aux_req, blk, hit_any;
  logic [15:0] vec;
  logic [3:0] pend;
  logic [6:0] stdreq;
  logic [7:0] d;
  logic v;
  int n_errors = 0;
  int n_tests = 0;
  int map[9] = '{0, 1, 2, 3, 4, 4, 5, 6, 6};
  logic [7:0] sa[6] = '{`AIBU_ADDR_SERIAL_PERIPH_DATA_REG, `AIBU_ADDR_SERIAL_PERIPH_DATA_REG, `AIBU_DEF_KHZ_ADDR, `AIBU_DEF_ADC_LSB_ADDR,
                        `AIBU_DEF_SUM_LSB_ADDR, `AIBU_DEF_ONE_HZ_ADDR};
  logic [3:0] pexp[6] = '{4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'h0};

  always #10 ref_clk = ~ref_clk;

  aibu_core_model core_u (.ref_clk(ref_clk), .sfr_req(req), .sfr_rdata_q(rdata), .sfr_rdata_valid_q(rvalid));

  aibu_top dut_u (
    .ref_clk(ref_clk), .reset_n(reset_n), .sfr_req(req), .sfr_rdata_q(rdata), .sfr_rdata_valid_q(rvalid),
    .one_hz_tick(ev[7]), .khz_tick(ev[4]), .accumulator_done(ev[6]), .conversion_done(ev[5]),
    .serial_periph_tx_done(ev[3]), .serial_periph_rx_done(ev[2]), .analog_lowv(alv), .digital_lowv(dlv),
    .timer_a_overflow(src[1]), .timer_b_overflow(src[3]), .timer_c_overflow(src[6]),
    .uart_a_rx_done(src[5]), .uart_a_tx_done(src[4]), .uart_b_rx_done(src[8]), .uart_b_tx_done(src[7]),
    .pin_irq_a(src[0]), .pin_irq_b(src[2]), .memory_control_selector(sel), .mem_access(acc),
    .aux_irq_req_q(aux_req), .aux_irq_vector(vec), .aux_pending_q(pend), .std_irq_req_q(stdreq),
    .conversion_update_block(blk), .break_hit_any(hit_any));

  // ==========================================================================
  // Helpers
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    core_u.rd(a, d, v);
    `CHK(v, 1'b1)
    `CHK(d, e)
  endtask

  task automatic wait_n(input int n);
    repeat (n) @(posedge ref_clk);
  endtask

  task automatic pulse(input logic [7:0] m);
    @(posedge ref_clk) ev <= m[7:2];
    @(posedge ref_clk) ev <= '0;
  endtask

  task automatic access(input logic s, input logic [15:0] a);
    @(posedge ref_clk) acc <= '{valid: 1'b1, space: s, addr: a};
    @(posedge ref_clk) acc <= '{valid: 1'b0, space: ~s, addr: ~a};
  endtask

  // ==========================================================================
  // Scenarios
  task automatic t_reset();
    for (int a = 'hA5; a <= 'hAB; a++) rchk(8'(a), 8'h00);
    rchk(`AIBU_ADDR_EXT_IRQ_CONTROL, 8'h00);
    core_u.rd(8'h50, d, v);
    `CHK(v, 1'b0)
    core_u.wr(`AIBU_ADDR_PEND, 8'hFF);
    rchk(`AIBU_ADDR_PEND, 8'h00);
    `CHK(vec, 16'h0033)
  endtask

  // The standard enable register stays 00h here, so the request also shows the global gate ignoring aux sources.
  task automatic t_aux();
    core_u.wr(`AIBU_ADDR_MASK, 8'hFF);
    core_u.wr(`AIBU_ADDR_EXT_IRQ_CONTROL, 8'h10);
    pulse(8'hFC);
    wait_n(2);
    rchk(`AIBU_ADDR_MASK, 8'hFC);
    rchk(`AIBU_ADDR_FLAGS, 8'hFC);
    rchk(`AIBU_ADDR_PEND, 8'h03);
    `CHK(aux_req, 1'b1)
    `CHK(blk, 1'b1)
    core_u.wr(`AIBU_ADDR_EXT_IRQ_CONTROL, 8'h00);
    wait_n(2);
    `CHK(aux_req, 1'b0)
    core_u.wr(`AIBU_ADDR_EXT_IRQ_CONTROL, 8'h10);
    core_u.wr(`AIBU_ADDR_MASK, 8'hF0);
    wait_n(2);
    rchk(`AIBU_ADDR_FLAGS, 8'hF0);
    `CHK(pend, 4'h5)
    core_u.wr(`AIBU_ADDR_MASK, 8'hFF);
    for (int i = 0; i < 6; i++) begin
      if (i == 1) core_u.wr(sa[i], 8'h5A);
      else core_u.rd(sa[i], d, v);
      wait_n(2);
      `CHK(pend, pexp[i])
      `CHK(blk, 1'(i < 3))
    end
    `CHK(aux_req, 1'b0)
  endtask

  task automatic t_lowv();
    @(posedge ref_clk) alv <= 1'b1;
    wait_n(5);
    `CHK(pend, 4'h2)
    rchk(`AIBU_ADDR_FLAGS, 8'h02);
    @(posedge ref_clk) dlv <= 1'b1;
    wait_n(5);
    `CHK(pend, 4'h1)
    @(posedge ref_clk) dlv <= 1'b0;
    wait_n(5);
    `CHK(pend, 4'h2)
    @(posedge ref_clk) alv <= 1'b0;
    wait_n(5);
    `CHK(pend, 4'h0)
  endtask

  task automatic t_std();
    core_u.wr(`AIBU_ADDR_STDIE, 8'h7F);
    @(posedge ref_clk) src <= '1;
    wait_n(2);
    `CHK(stdreq, 7'h00)
    rchk(`AIBU_ADDR_STDIE, 8'h7F);
    core_u.wr(`AIBU_ADDR_STDIE, 8'hFF);
    for (int i = 0; i < 9; i++) begin
      @(posedge ref_clk) src <= 9'h001 << i;
      wait_n(2);
      `CHK(stdreq, 7'h01 << map[i])
    end
    core_u.wr(`AIBU_ADDR_STDIE, 8'hAA);
    @(posedge ref_clk) src <= '1;
    wait_n(2);
    `CHK(stdreq, 7'h2A)
    @(posedge ref_clk) src <= '0;
  endtask

  task automatic t_break();
    core_u.wr(`AIBU_ADDR_BPL, 8'h34);
    core_u.wr(`AIBU_ADDR_BPH, 8'h12);
    @(posedge ref_clk) sel <= 1'b1;
    core_u.wr(`AIBU_ADDR_BREAK_CONTROL, 8'h03);
    rchk(`AIBU_ADDR_BREAK_CONTROL, 8'h03);
    rchk(`AIBU_ADDR_BPL, 8'h34);
    rchk(`AIBU_ADDR_BPH, 8'h12);
    access(1'b0, 16'h1234);
    access(1'b1, 16'h1235);
    wait_n(2);
    `CHK(hit_any, 1'b0)
    access(1'b1, 16'h1234);
    wait_n(2);
    `CHK(hit_any, 1'b1)
    `CHK(pend, 4'h1)
    rchk(`AIBU_ADDR_BREAK_CONTROL, 8'h83);
    @(posedge ref_clk) sel <= 1'b0;
    rchk(`AIBU_ADDR_BREAK_CONTROL, 8'h80);
    core_u.wr(`AIBU_ADDR_BREAK_CONTROL, 8'h00);
    wait_n(2);
    `CHK(hit_any, 1'b1)
    @(posedge ref_clk) sel <= 1'b1;
    core_u.wr(`AIBU_ADDR_BREAK_CONTROL, 8'h81);
    wait_n(2);
    `CHK(hit_any, 1'b0)
    `CHK(pend, 4'h0)
    access(1'b0, 16'h1234);
    wait_n(2);
    `CHK(hit_any, 1'b1)
  endtask

  // ==========================================================================
  // Sequence and verdict
  task automatic close_out();
    if (n_errors == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  initial begin
    repeat (6) @(posedge ref_clk);
    reset_n <= 1'b1;
    t_reset();
    t_aux();
    t_lowv();
    t_std();
    t_break();
    close_out();
  end

  // The scenarios need well under a thousand cycles; this only cuts a hang.
  initial begin
    repeat (5000) @(posedge ref_clk);
    n_errors++;
    close_out();
  end
endmodule
